/* File: core/dswk_pkg.sv */
package dswk_pkg;
   // --------------------------------------------------------------
   // widths and reset values
   // --------------------------------------------------------------
   localparam int DUR_W = 32;
   localparam int LEAD_W = 10;
   localparam logic [9:0] LEAD_RST = 10'h000;
   localparam logic [9:0] RELEASE_RST = 10'h001;
   localparam logic [9:0] EXT_PULSE_RST = 10'h002;
   localparam logic [31:0] DUR_RST = 32'h0000_0000;
   // --------------------------------------------------------------
   // base slot timing
   // --------------------------------------------------------------
   localparam int SLOT_NS = 625000;
   localparam int LP_PERIOD_NS = 30518;
   // lp cycles in one 625 us slot, rounded down
   localparam int SLOT_LP_CYC = SLOT_NS / LP_PERIOD_NS;
   // --------------------------------------------------------------
   // timer states
   // --------------------------------------------------------------
   typedef enum logic [3:0] {
      DSWK_ACTIVE = 4'b0001,
      DSWK_SLEEP = 4'b0010,
      DSWK_EXPIRED = 4'b0100,
      DSWK_EXIT = 4'b1000
   } dswk_state_t;
endpackage

/* File: core/dswk_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dswk_if;
   // host/power manager to core
   logic [9:0] wake_lead_cycles;
   logic [9:0] wake_release_cycles;
   logic [9:0] ext_wake_pulse_cycles;
   logic [31:0] sleep_duration_cycles;
   logic sleep_enter;
   logic ext_wake_req;
   logic ext_wake_block;
   logic core_clk_en;
   logic radio_domain_up;
   logic lp_tick;
   // core to host/power manager
   logic early_wake_irq;
   logic sleep_exit_irq;
   logic radio_powerdown_ok;
   logic in_deep_sleep;
   logic [31:0] actual_sleep_length;
   modport core (
      input wake_lead_cycles, wake_release_cycles, ext_wake_pulse_cycles,
      input sleep_duration_cycles, sleep_enter, ext_wake_req, ext_wake_block,
      input core_clk_en, radio_domain_up, lp_tick,
      output early_wake_irq, sleep_exit_irq, radio_powerdown_ok, in_deep_sleep,
      output actual_sleep_length
   );
   modport host (
      output wake_lead_cycles, wake_release_cycles, ext_wake_pulse_cycles,
      output sleep_duration_cycles, sleep_enter, ext_wake_req, ext_wake_block,
      output core_clk_en, radio_domain_up, lp_tick,
      input early_wake_irq, sleep_exit_irq, radio_powerdown_ok, in_deep_sleep,
      input actual_sleep_length
   );
endinterface
`default_nettype wire

/* File: core/dswk_core.sv */
`timescale 1ns/1ps
`default_nettype none
module dswk_core #(
   parameter int DUR_W = dswk_pkg::DUR_W,
   parameter int LEAD_W = dswk_pkg::LEAD_W
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   dswk_if.core lnk
);
   initial begin
      if (DUR_W != 32 || LEAD_W != 10 || LEAD_W > DUR_W) begin
         $error("dswk_core: unsupported widths");
      end
   end
   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   dswk_pkg::dswk_state_t state_r;
   logic [DUR_W-1:0] remain_r;
   logic [DUR_W-1:0] elapsed_r;
   logic [LEAD_W-1:0] ext_cnt_r;
   logic ext_seen_r;
   logic ewi_r;
   logic sxi_r;
   logic pdok_r;
   logic [DUR_W-1:0] len_r;
   logic [15:0] slot_cnt_r;
   logic ext_ok;
   logic [DUR_W-1:0] lead_w;
   logic [DUR_W-1:0] rel_w;
   logic in_sleep;
   assign ext_ok = lnk.ext_wake_req & ~lnk.ext_wake_block;
   assign lead_w = {{(DUR_W-LEAD_W){1'b0}}, lnk.wake_lead_cycles};
   assign rel_w = {{(DUR_W-LEAD_W){1'b0}}, lnk.wake_release_cycles};
   assign in_sleep = (state_r == dswk_pkg::DSWK_SLEEP) || (state_r == dswk_pkg::DSWK_EXPIRED);
   // --------------------------------------------------------------
   // sleep state machine
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_r <= dswk_pkg::DSWK_ACTIVE;
      end else begin
         case (state_r)
            dswk_pkg::DSWK_ACTIVE: begin
               if (lnk.sleep_enter && !lnk.ext_wake_req) begin
                  state_r <= dswk_pkg::DSWK_SLEEP;
               end
            end
            dswk_pkg::DSWK_SLEEP: begin
               if (ext_seen_r || (lnk.lp_tick && remain_r <= 32'h0000_0001)) begin
                  state_r <= dswk_pkg::DSWK_EXPIRED;
               end
            end
            dswk_pkg::DSWK_EXPIRED: begin
               // early wake already issued before this point
               if (lnk.core_clk_en && lnk.radio_domain_up && !ewi_r) begin
                  state_r <= dswk_pkg::DSWK_EXIT;
               end
            end
            dswk_pkg::DSWK_EXIT: begin
               state_r <= dswk_pkg::DSWK_ACTIVE;
            end
            default: begin
               state_r <= dswk_pkg::DSWK_ACTIVE;
            end
         endcase
      end
   end
   // --------------------------------------------------------------
   // sleep timer and elapsed count
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         remain_r <= dswk_pkg::DUR_RST;
         elapsed_r <= dswk_pkg::DUR_RST;
      end else if (state_r == dswk_pkg::DSWK_ACTIVE) begin
         remain_r <= lnk.sleep_duration_cycles;
         elapsed_r <= dswk_pkg::DUR_RST;
      end else if (in_sleep && lnk.lp_tick) begin
         if (remain_r != dswk_pkg::DUR_RST) begin
            remain_r <= remain_r - 32'h0000_0001;
         end
         elapsed_r <= elapsed_r + 32'h0000_0001;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         len_r <= dswk_pkg::DUR_RST;
      end else if (state_r == dswk_pkg::DSWK_EXIT) begin
         len_r <= elapsed_r;
      end
   end
   // --------------------------------------------------------------
   // slot timing on lp clock
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         slot_cnt_r <= 16'h0000;
      end else if (in_sleep && lnk.lp_tick) begin
         if (slot_cnt_r >= 16'(dswk_pkg::SLOT_LP_CYC - 1)) begin
            slot_cnt_r <= 16'h0000;
         end else begin
            slot_cnt_r <= slot_cnt_r + 16'h0001;
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pdok_r <= 1'b0;
      end else begin
         pdok_r <= (state_r == dswk_pkg::DSWK_SLEEP);
      end
   end
   // --------------------------------------------------------------
   // external wake capture
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ext_seen_r <= 1'b0;
         ext_cnt_r <= 10'h000;
      end else if (state_r == dswk_pkg::DSWK_SLEEP && ext_ok && !ext_seen_r) begin
         ext_seen_r <= 1'b1;
         ext_cnt_r <= lnk.ext_wake_pulse_cycles - lnk.wake_release_cycles;
      end else if (state_r == dswk_pkg::DSWK_ACTIVE) begin
         ext_seen_r <= 1'b0;
         ext_cnt_r <= 10'h000;
      end else if (lnk.lp_tick && ext_cnt_r != 10'h000) begin
         ext_cnt_r <= ext_cnt_r - 10'h001;
      end
   end
   // --------------------------------------------------------------
   // interrupts
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ewi_r <= 1'b0;
      end else if (state_r == dswk_pkg::DSWK_SLEEP && ext_ok && !ext_seen_r) begin
         ewi_r <= 1'b1;
      end else if (ext_seen_r) begin
         ewi_r <= (ext_cnt_r > 10'h001) || (ext_cnt_r == 10'h001 && !lnk.lp_tick);
      end else if (state_r == dswk_pkg::DSWK_SLEEP) begin
         ewi_r <= (remain_r <= lead_w) && (remain_r > rel_w);
      end else begin
         ewi_r <= 1'b0;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sxi_r <= 1'b0;
      end else begin
         sxi_r <= (state_r == dswk_pkg::DSWK_EXIT);
      end
   end
   assign lnk.early_wake_irq = ewi_r;
   assign lnk.sleep_exit_irq = sxi_r;
   assign lnk.radio_powerdown_ok = pdok_r;
   assign lnk.in_deep_sleep = pdok_r;
   assign lnk.actual_sleep_length = len_r;
endmodule
`default_nettype wire

/* File: core/dswk_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dswk_host (
   input wire logic mclk_i,
   input wire logic rst_i,
   dswk_if.host lnk,
   input wire logic [9:0] lead_i,
   input wire logic [9:0] release_i,
   input wire logic [9:0] pulse_i,
   input wire logic [31:0] duration_i,
   input wire logic sleep_req_i,
   input wire logic wake_req_i,
   input wire logic wake_block_i,
   input wire logic lp_tick_i,
   output logic early_wake_o,
   output logic sleep_exit_o,
   output logic busy_o,
   output logic [31:0] sleep_len_o
);
   // --------------------------------------------------------------
   // host sequencer
   // --------------------------------------------------------------
   typedef enum logic [4:0] {
      DSWK_H_IDLE = 5'b00001,
      DSWK_H_ENTER = 5'b00010,
      DSWK_H_WAITPD = 5'b00100,
      DSWK_H_ASLEEP = 5'b01000,
      DSWK_H_WAKE = 5'b10000
   } dswk_hstate_t;
   dswk_hstate_t st_r;
   logic [9:0] lead_r;
   logic [9:0] rel_r;
   logic [9:0] pulse_r;
   logic [31:0] dur_r;
   logic ewr_r;
   logic clk_en_r;
   logic radio_up_r;
   logic tick_r;
   logic ew_r;
   logic sx_r;
   logic [31:0] len_r;
   logic busy_r;
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         st_r <= DSWK_H_IDLE;
         lead_r <= dswk_pkg::LEAD_RST;
         rel_r <= dswk_pkg::RELEASE_RST;
         pulse_r <= dswk_pkg::EXT_PULSE_RST;
         dur_r <= dswk_pkg::DUR_RST;
         clk_en_r <= 1'b1;
         radio_up_r <= 1'b1;
      end else begin
         case (st_r)
            DSWK_H_IDLE: begin
               if (sleep_req_i) begin
                  lead_r <= lead_i;
                  rel_r <= release_i;
                  pulse_r <= pulse_i;
                  dur_r <= (duration_i > {22'h00_0000, lead_i}) ?
                     duration_i : ({22'h00_0000, lead_i} + 32'h0000_0001);
                  st_r <= DSWK_H_ENTER;
               end
            end
            DSWK_H_ENTER: begin
               st_r <= DSWK_H_WAITPD;
            end
            DSWK_H_WAITPD: begin
               if (lnk.radio_powerdown_ok) begin
                  clk_en_r <= 1'b0;
                  radio_up_r <= 1'b0;
                  st_r <= DSWK_H_ASLEEP;
               end else if (!lnk.in_deep_sleep && lnk.sleep_exit_irq) begin
                  st_r <= DSWK_H_IDLE;
               end
            end
            DSWK_H_ASLEEP: begin
               if (lnk.early_wake_irq) begin
                  st_r <= DSWK_H_WAKE;
               end
            end
            DSWK_H_WAKE: begin
               clk_en_r <= 1'b1;
               radio_up_r <= 1'b1;
               if (lnk.sleep_exit_irq) begin
                  st_r <= DSWK_H_IDLE;
               end
            end
            default: begin
               st_r <= DSWK_H_IDLE;
            end
         endcase
      end
   end
   // --------------------------------------------------------------
   // wake request and pass-through flops
   // --------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ewr_r <= 1'b0;
         tick_r <= 1'b0;
         ew_r <= 1'b0;
         sx_r <= 1'b0;
         len_r <= 32'h0000_0000;
         busy_r <= 1'b0;
      end else begin
         busy_r <= (st_r != DSWK_H_IDLE);
         ewr_r <= wake_req_i && (st_r == DSWK_H_ASLEEP || st_r == DSWK_H_WAKE);
         tick_r <= lp_tick_i;
         ew_r <= lnk.early_wake_irq;
         sx_r <= lnk.sleep_exit_irq;
         len_r <= lnk.actual_sleep_length;
      end
   end
   assign lnk.wake_lead_cycles = lead_r;
   assign lnk.wake_release_cycles = rel_r;
   assign lnk.ext_wake_pulse_cycles = pulse_r;
   assign lnk.sleep_duration_cycles = dur_r;
   assign lnk.sleep_enter = (st_r == DSWK_H_ENTER);
   assign lnk.ext_wake_req = ewr_r;
   assign lnk.ext_wake_block = wake_block_i;
   assign lnk.core_clk_en = clk_en_r;
   assign lnk.radio_domain_up = radio_up_r;
   assign lnk.lp_tick = tick_r;
   assign early_wake_o = ew_r;
   assign sleep_exit_o = sx_r;
   assign busy_o = busy_r;
   assign sleep_len_o = len_r;
endmodule
`default_nettype wire

/* File: tb/dswk_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dswk_props (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sleep_enter,
   input wire logic ext_wake_req,
   input wire logic ext_wake_block,
   input wire logic core_clk_en,
   input wire logic radio_domain_up,
   input wire logic lp_tick,
   input wire logic early_wake_irq,
   input wire logic sleep_exit_irq,
   input wire logic radio_powerdown_ok,
   input wire logic in_deep_sleep
);
   // ------------------------------------------------------------
   // early wake seen since last exit
   // ------------------------------------------------------------
   logic seen_r;
   always_ff @(posedge mclk_i) begin
      if (rst_i || sleep_exit_irq) begin
         seen_r <= 1'b0;
      end else if (early_wake_irq) begin
         seen_r <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_order;
      sleep_exit_irq |-> seen_r && !early_wake_irq;
   endproperty
   a_order: assert property (p_order) else $error("exit without prior early wake");
   property p_lead;
      $rose(early_wake_irq) |-> $past(lp_tick, 2) || ($past(ext_wake_req) && !$past(ext_wake_block));
   endproperty
   a_lead: assert property (p_lead) else $error("early wake rose off a tick");
   property p_release;
      $fell(early_wake_irq) && !ext_wake_req |-> $past(lp_tick, 2);
   endproperty
   a_release: assert property (p_release) else $error("early wake fell off a tick");
   property p_ext_now;
      $rose(ext_wake_req) && !ext_wake_block && in_deep_sleep |=> early_wake_irq;
   endproperty
   a_ext_now: assert property (p_ext_now) else $error("wake request not answered");
   property p_block;
      $rose(early_wake_irq) && $past(ext_wake_block) |-> $past(lp_tick, 2);
   endproperty
   a_block: assert property (p_block) else $error("blocked request raised early wake");
   property p_exit_cond;
      sleep_exit_irq |-> $past(core_clk_en, 2) && $past(radio_domain_up, 2);
   endproperty
   a_exit_cond: assert property (p_exit_cond) else $error("exit without clocks or radio");
   property p_pd_ok;
      $rose(radio_powerdown_ok) |-> $past(sleep_enter) || $past(sleep_enter, 2);
   endproperty
   a_pd_ok: assert property (p_pd_ok) else $error("powerdown ok without entry");
   property p_no_entry;
      sleep_enter && ext_wake_req && !in_deep_sleep |=> !in_deep_sleep [*2];
   endproperty
   a_no_entry: assert property (p_no_entry) else $error("entered sleep under request");
   property p_exit_pulse;
      sleep_exit_irq |=> !sleep_exit_irq && !in_deep_sleep;
   endproperty
   a_exit_pulse: assert property (p_exit_pulse) else $error("exit pulse too long");
endmodule
`default_nettype wire

/* File: tb/tb_radio_core_deep_sleep_wakeup.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_radio_core_deep_sleep_wakeup;
   logic mclk_i;
   logic rst_i;
   logic [9:0] lead_i, release_i, pulse_i, ld, rl, pl;
   logic [31:0] duration_i, dr;
   logic sleep_req_i, wake_req_i, wake_block_i, lp_tick_i;
   logic early_wake_o, sleep_exit_o, busy_o;
   logic [31:0] sleep_len_o;
   int n_mismatch, checks_done, n_hi, cyc, tdiv, i;
   dswk_if lnk_i ();
   dswk_core u_dswk_core (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(lnk_i));
   dswk_host u_dswk_host (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(lnk_i), .lead_i(lead_i),
      .release_i(release_i), .pulse_i(pulse_i), .duration_i(duration_i),
      .sleep_req_i(sleep_req_i), .wake_req_i(wake_req_i), .wake_block_i(wake_block_i),
      .lp_tick_i(lp_tick_i), .early_wake_o(early_wake_o), .sleep_exit_o(sleep_exit_o),
      .busy_o(busy_o), .sleep_len_o(sleep_len_o));
   dswk_props u_dswk_props (.mclk_i(mclk_i), .rst_i(rst_i), .sleep_enter(lnk_i.sleep_enter),
      .ext_wake_req(lnk_i.ext_wake_req), .ext_wake_block(lnk_i.ext_wake_block),
      .core_clk_en(lnk_i.core_clk_en), .radio_domain_up(lnk_i.radio_domain_up),
      .lp_tick(lnk_i.lp_tick), .early_wake_irq(lnk_i.early_wake_irq),
      .sleep_exit_irq(lnk_i.sleep_exit_irq), .radio_powerdown_ok(lnk_i.radio_powerdown_ok),
      .in_deep_sleep(lnk_i.in_deep_sleep));
   // ------------------------------------------------------------
   // clock, low power tick, monitors
   // ------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   always @(negedge mclk_i) begin
      tdiv = (tdiv == 3) ? 0 : tdiv + 1;
      lp_tick_i = (tdiv == 0);
   end
   always @(posedge mclk_i) begin
      if (lnk_i.lp_tick === 1'b1 && lnk_i.early_wake_irq === 1'b1) begin
         n_hi = n_hi + 1;
      end
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_mismatch = n_mismatch + 1;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // mode 0 timer, 1 external wake, 2 external wake blocked
   task automatic run_sleep(input int mode);
      int k;
      for (k = 0; k < 100 && busy_o !== 1'b0; k++) @(negedge mclk_i);
      lead_i = ld;
      release_i = rl;
      pulse_i = pl;
      duration_i = dr;
      wake_block_i = (mode == 2);
      sleep_req_i = 1'b1;
      @(negedge mclk_i);
      sleep_req_i = 1'b0;
      for (k = 0; k < 100 && lnk_i.in_deep_sleep !== 1'b1; k++) @(negedge mclk_i);
      n_hi = 0;
      if (mode != 0) begin
         repeat (12) @(negedge mclk_i);
         wake_req_i = 1'b1;
         repeat (2) @(posedge mclk_i);
         #1;
         check("early wake on request", 32'(lnk_i.early_wake_irq), 32'(mode == 1));
      end
      for (k = 0; k < 3000 && sleep_exit_o !== 1'b1; k++) @(negedge mclk_i);
      check("sleep exit", 32'(sleep_exit_o), 32'h0000_0001);
      @(negedge mclk_i);
      check("high ticks", 32'(n_hi), 32'((mode == 1) ? pl - rl : ld - rl));
      if (mode == 1) begin
         check("short length", 32'(sleep_len_o < dr), 32'h0000_0001);
      end else begin
         check("full length", 32'(sleep_len_o >= dr), 32'h0000_0001);
      end
      wake_req_i = 1'b0;
      wake_block_i = 1'b0;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {lead_i, release_i, pulse_i, duration_i} = '0;
      {sleep_req_i, wake_req_i, wake_block_i, lp_tick_i} = '0;
      {n_mismatch, checks_done, n_hi, cyc, tdiv} = '0;
      void'($urandom(32'h733d));
      repeat (4) @(negedge mclk_i);
      rst_i = 1'b0;
      ld = 10'h002;
      rl = 10'h001;
      pl = 10'h002;
      dr = 32'h0000_0003;
      run_sleep(0);
      dr = 32'h0000_0020;
      run_sleep(1);
      run_sleep(2);
      for (i = 0; i < 9; i++) begin
         ld = 10'($urandom_range(6, 2));
         rl = 10'($urandom_range(32'(ld) - 1, 1));
         pl = rl + 10'($urandom_range(3, 1));
         dr = 32'(ld) + 32'($urandom_range(20, 8));
         run_sleep(i % 3);
      end
      summarize();
   end
endmodule
`default_nettype wire
